// ### logic/fdsel_pkg.sv
// package: constants and types for the flexible disk select and step controller
package fdsel_pkg;

  // clock rate
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned CLK_NS          = 40;

  // documented waits, in their own units
  localparam int unsigned DC_SETTLE_MS    = 90;
  localparam int unsigned SPIN_SETTLE_MS  = 2000;
  localparam int unsigned SPIN_SETTLE_CYC = SPIN_SETTLE_MS * (CLK_HZ / 1000);
  localparam int unsigned DC_SETTLE_CYC   = DC_SETTLE_MS * (CLK_HZ / 1000);

  // step pulse shape and spacing, plain defaults
  localparam int unsigned STEP_LOW_NS     = 1000;
  localparam int unsigned STEP_LOW_CYC    = (STEP_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned STEP_GAP_US     = 3000;
  localparam int unsigned STEP_GAP_CYC    = (STEP_GAP_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned DIR_SETUP_NS    = 1000;
  localparam int unsigned DIR_SETUP_CYC   = (DIR_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned HOME_MAX_STEPS  = 255;

  // register offsets (byte addresses)
  localparam logic [7:0] ADDR_CTRL        = 8'h00;
  localparam logic [7:0] ADDR_CMD         = 8'h04;
  localparam logic [7:0] ADDR_STAT        = 8'h08;
  localparam logic [7:0] ADDR_TRACK       = 8'h0C;

  // control register field positions
  localparam int unsigned CTRL_UNIT_LSB   = 0;   // 3 bits: target drive 0..7
  localparam int unsigned CTRL_SIDE_BIT   = 3;   // side 0/1
  localparam int unsigned CTRL_MODE_LSB   = 4;   // 2 bits addressing mode
  localparam int unsigned CTRL_ALTS1_LSB  = 8;   // 2 bits: side-1 line in alternate mode
  localparam int unsigned CTRL_SEL_BIT    = 12;  // hold selection
  localparam int unsigned CTRL_PWRSAVE    = 13;  // power reduction active
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;

  // command codes
  localparam logic [1:0] CMD_NONE         = 2'h0;
  localparam logic [1:0] CMD_HOME         = 2'h1;
  localparam logic [1:0] CMD_SEEK         = 2'h2;
  localparam logic [1:0] CMD_STEP         = 2'h3;

  // select addressing modes
  typedef enum logic [1:0] {
    FDSEL_MODE_STD    = 2'b00,
    FDSEL_MODE_BINARY = 2'b01,
    FDSEL_MODE_ALT    = 2'b10
  } fdsel_mode_t;

  // cable lines toward the drives, low active except the seek heading level (high steps outward)
  typedef struct packed {
    logic [3:0] unit_choice_n;
    logic       side_choice_n;
    logic       seek_heading_level;
    logic       head_advance_pulse_n;
    logic       record_enable_n;
    logic       power_reduce_n;
  } fdsel_cable_t;

  localparam fdsel_cable_t CABLE_IDLE = '{4'hF, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

  // selection decode, used only by the controller's cable drive, not by the step engine
  function automatic logic [3:0] fdsel_decode(input fdsel_mode_t mode, input logic [2:0] unit,
                                              input logic side, input logic [1:0] alt_s1);
    logic [3:0] lines;
    lines = 4'hF;
    case (mode)
      FDSEL_MODE_STD:    lines[unit[1:0]] = 1'b0;
      FDSEL_MODE_BINARY: lines = {~unit[2], ~unit[1], ~unit[0], 1'b0};
      FDSEL_MODE_ALT:    lines[side ? alt_s1 : unit[1:0]] = 1'b0;
      default:           lines = 4'hF;
    endcase
    return lines;
  endfunction

endpackage

// ### logic/fdsel_stepper.sv
// step pulse generator: one low pulse per request, direction set up ahead
`timescale 1ns/1ps
module fdsel_stepper
  import fdsel_pkg::*;
#(
  parameter int unsigned GAP_CYC = STEP_GAP_CYC
)
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  input  wire logic go,
  input  wire logic outward,
  output logic      busy,
  output logic      dir_level,
  output logic      pulse_n,
  output logic      done
);

  typedef enum logic [1:0] {
    FDSEL_ST_IDLE  = 2'b00,
    FDSEL_ST_SETUP = 2'b01,
    FDSEL_ST_LOW   = 2'b10,
    FDSEL_ST_GAP   = 2'b11
  } fdsel_st_t;

  fdsel_st_t   state_q, state_d;
  logic [17:0] cnt_q, cnt_d;
  logic        dir_q, dir_d;
  logic        pulse_n_q, pulse_n_d;
  logic        done_q, done_d;

  // next-state: direction settles before the edge, movement is on the rising end
  always_comb
  begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    dir_d     = dir_q;
    pulse_n_d = pulse_n_q;
    done_d    = 1'b0;
    case (state_q)
      FDSEL_ST_IDLE:
      begin
        if (go)
        begin
          dir_d   = outward;
          cnt_d   = 18'(DIR_SETUP_CYC);
          state_d = FDSEL_ST_SETUP;
        end
      end
      FDSEL_ST_SETUP:
      begin
        if (cnt_q <= 18'd1)
        begin
          pulse_n_d = 1'b0;
          cnt_d     = 18'(STEP_LOW_CYC);
          state_d   = FDSEL_ST_LOW;
        end
        else
          cnt_d = cnt_q - 18'd1;
      end
      FDSEL_ST_LOW:
      begin
        if (cnt_q <= 18'd1)
        begin
          pulse_n_d = 1'b1;
          cnt_d     = 18'(GAP_CYC);
          state_d   = FDSEL_ST_GAP;
        end
        else
          cnt_d = cnt_q - 18'd1;
      end
      FDSEL_ST_GAP:
      begin
        if (cnt_q <= 18'd1)
        begin
          done_d  = 1'b1;
          state_d = FDSEL_ST_IDLE;
        end
        else
          cnt_d = cnt_q - 18'd1;
      end
      default: state_d = FDSEL_ST_IDLE;
    endcase
  end

  // registers only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q   <= FDSEL_ST_IDLE;
      cnt_q     <= 18'h0_0000;
      dir_q     <= 1'b1;
      pulse_n_q <= 1'b1;
      done_q    <= 1'b0;
    end
    else if (clk_en)
    begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      dir_q     <= dir_d;
      pulse_n_q <= pulse_n_d;
      done_q    <= done_d;
    end
  end

  assign busy      = (state_q != FDSEL_ST_IDLE);
  assign dir_level = dir_q;
  assign pulse_n   = pulse_n_q;
  assign done      = done_q;

  // direction stays still while the pulse is low
  property p_dir_stable;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && !pulse_n_q) |-> $stable(dir_q);
  endproperty
  a_dir_stable: assert property (p_dir_stable) else $error("direction moved during step pulse");

  // a step pulse ends only as the stepper enters its gap
  property p_one_pulse;
    @(posedge pclk) disable iff (!presetn)
    ($rose(pulse_n_q) && clk_en) |-> (state_q == FDSEL_ST_GAP);
  endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("step pulse ended outside its slot");

endmodule // fdsel_stepper

// ### logic/fdsel_ctrl.sv
// host-side controller that selects drives and positions their heads
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module fdsel_ctrl
  import fdsel_pkg::*;
#(
  parameter int unsigned DC_WAIT_CYC   = DC_SETTLE_CYC,
  parameter int unsigned SPIN_WAIT_CYC = SPIN_SETTLE_CYC,
  parameter int unsigned STEP_WAIT_CYC = STEP_GAP_CYC
)
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         clk_en,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic         track_zero_flag_n,
  output fdsel_cable_t      cable
);

  typedef enum logic [2:0] {
    FDSEL_C_POWER = 3'b000,
    FDSEL_C_IDLE  = 3'b001,
    FDSEL_C_HOME  = 3'b010,
    FDSEL_C_SEEK  = 3'b011,
    FDSEL_C_WAIT  = 3'b100
  } fdsel_cs_t;

  // apb and control state
  logic [31:0]  ctrl_q, ctrl_d;
  logic [31:0]  prdata_q, prdata_d;
  logic         pready_q, pready_d;
  logic         pslverr_q, pslverr_d;
  fdsel_cs_t    cs_q, cs_d;
  logic [7:0]   track_q, track_d;
  logic [7:0]   target_q, target_d;
  logic [7:0]   steps_q, steps_d;
  logic         err_q, err_d;
  logic         done_q, done_d;
  logic [31:0]  dc_cnt_q, dc_cnt_d;
  logic [31:0]  spin_cnt_q, spin_cnt_d;
  logic         pwr_prev_q;
  logic         tz_meta_q, tz_sync_q;
  fdsel_cable_t cable_q, cable_d;

  // stepper handshake
  logic         st_go;
  logic         st_out;
  logic         st_busy;
  logic         st_dir;
  logic         st_pulse_n;
  logic         st_done;

  wire          wr_en    = psel && penable && pwrite && !pready_q;
  wire          rd_en    = psel && penable && !pwrite && !pready_q;
  wire          dc_ok    = (dc_cnt_q >= DC_WAIT_CYC);
  wire          spin_ok  = (spin_cnt_q >= SPIN_WAIT_CYC);
  wire          at_zero  = !tz_sync_q;
  wire          busy     = (cs_q == FDSEL_C_HOME) || (cs_q == FDSEL_C_SEEK) || (cs_q == FDSEL_C_WAIT);
  wire          mapped   = (paddr == ADDR_CTRL) || (paddr == ADDR_CMD) || (paddr == ADDR_STAT) ||
                           (paddr == ADDR_TRACK);

  // control fields
  fdsel_mode_t  mode;
  wire [2:0]    unit     = ctrl_q[CTRL_UNIT_LSB +: 3];
  wire          side     = ctrl_q[CTRL_SIDE_BIT];
  wire [1:0]    alt_s1   = ctrl_q[CTRL_ALTS1_LSB +: 2];
  wire          sel_hold = ctrl_q[CTRL_SEL_BIT];
  wire          pwr_save = ctrl_q[CTRL_PWRSAVE];
  assign mode = fdsel_mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);

  // apb slave: one wait state, answer in the cycle after the access phase starts
  always_comb
  begin
    ctrl_d    = ctrl_q;
    prdata_d  = prdata_q;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    if (psel && penable && !pready_q)
    begin
      pready_d  = 1'b1;
      pslverr_d = !mapped;
      if (wr_en && paddr == ADDR_CTRL && !busy)
        ctrl_d = pwdata;
      if (rd_en)
      begin
        case (paddr)
          ADDR_CTRL:  prdata_d = ctrl_q;
          ADDR_STAT:  prdata_d = {24'h00_0000, 1'b0, done_q, err_q, spin_ok, dc_ok, at_zero, busy,
                                  cs_q != FDSEL_C_POWER};
          ADDR_TRACK: prdata_d = {16'h0000, target_q, track_q};
          default:    prdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  // track zero flag comes off the cable: two flops before use
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tz_meta_q <= 1'b1;
      tz_sync_q <= 1'b1;
    end
    else if (clk_en)
    begin
      tz_meta_q <= track_zero_flag_n;
      tz_sync_q <= tz_meta_q;
    end
  end

  // command sequencer
  always_comb
  begin
    cs_d       = cs_q;
    track_d    = track_q;
    target_d   = target_q;
    steps_d    = steps_q;
    err_d      = err_q;
    done_d     = done_q;
    st_go      = 1'b0;
    st_out     = 1'b1;
    dc_cnt_d   = dc_ok ? dc_cnt_q : dc_cnt_q + 32'd1;
    spin_cnt_d = (pwr_save || (pwr_prev_q && !pwr_save)) ? 32'h0000_0000 :
                 (spin_ok ? spin_cnt_q : spin_cnt_q + 32'd1);
    case (cs_q)
      FDSEL_C_POWER:
        if (dc_ok)
          cs_d = FDSEL_C_IDLE;
      FDSEL_C_IDLE:
        if (wr_en && paddr == ADDR_CMD)
        begin
          done_d = 1'b0;
          err_d  = 1'b0;
          steps_d = 8'h00;                              // a stale homing count would send a seek home
          case (pwdata[1:0])
            CMD_HOME: cs_d = FDSEL_C_HOME;
            CMD_SEEK:
            begin
              target_d = pwdata[15:8];
              cs_d     = FDSEL_C_SEEK;
            end
            CMD_STEP:
            begin
              target_d = pwdata[2] ? track_q - 8'd1 : track_q + 8'd1;
              cs_d     = FDSEL_C_SEEK;
            end
            default: cs_d = FDSEL_C_IDLE;
          endcase
        end
      FDSEL_C_HOME:
        if (!st_busy)
        begin
          if (at_zero)
          begin
            track_d = 8'h00;
            done_d  = 1'b1;
            cs_d    = FDSEL_C_IDLE;
          end
          else if (steps_q == 8'(HOME_MAX_STEPS))
          begin
            err_d = 1'b1;
            cs_d  = FDSEL_C_IDLE;
          end
          else
          begin
            st_go   = 1'b1;
            st_out  = 1'b1;
            steps_d = steps_q + 8'd1;
            cs_d    = FDSEL_C_WAIT;
          end
        end
      FDSEL_C_SEEK:
        if (!st_busy)
        begin
          if (target_q == track_q)
          begin
            done_d = 1'b1;
            cs_d   = FDSEL_C_IDLE;
          end
          else
          begin
            st_go  = 1'b1;
            st_out = (target_q < track_q);
            track_d = (target_q < track_q) ? track_q - 8'd1 : track_q + 8'd1;
            cs_d   = FDSEL_C_WAIT;
          end
        end
      FDSEL_C_WAIT:
        if (st_done)
          cs_d = (steps_q != 8'h00) ? FDSEL_C_HOME : FDSEL_C_SEEK;   // only homing counts its steps
      default: cs_d = FDSEL_C_IDLE;
    endcase
  end

  // cable drive: selection from the decode, record enable never active
  always_comb
  begin
    cable_d                      = CABLE_IDLE;
    cable_d.record_enable_n      = 1'b1;
    cable_d.power_reduce_n       = !pwr_save;
    cable_d.seek_heading_level   = st_dir;
    cable_d.head_advance_pulse_n = st_pulse_n;
    if (sel_hold || busy)
      cable_d.unit_choice_n = fdsel_decode(mode, unit, side, alt_s1);
    cable_d.side_choice_n = (mode == FDSEL_MODE_STD) ? !side : 1'b1;
  end

  // registers only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q     <= CTRL_RESET;
      prdata_q   <= 32'h0000_0000;
      pready_q   <= 1'b0;
      pslverr_q  <= 1'b0;
      cs_q       <= FDSEL_C_POWER;
      track_q    <= 8'h00;
      target_q   <= 8'h00;
      steps_q    <= 8'h00;
      err_q      <= 1'b0;
      done_q     <= 1'b0;
      dc_cnt_q   <= 32'h0000_0000;
      spin_cnt_q <= 32'h0000_0000;
      pwr_prev_q <= 1'b0;
      cable_q    <= CABLE_IDLE;
    end
    else if (clk_en)
    begin
      ctrl_q     <= ctrl_d;
      prdata_q   <= prdata_d;
      pready_q   <= pready_d;
      pslverr_q  <= pslverr_d;
      cs_q       <= cs_d;
      track_q    <= track_d;
      target_q   <= target_d;
      steps_q    <= steps_d;
      err_q      <= err_d;
      done_q     <= done_d;
      dc_cnt_q   <= dc_cnt_d;
      spin_cnt_q <= spin_cnt_d;
      pwr_prev_q <= pwr_save;
      cable_q    <= cable_d;
    end
  end

  fdsel_stepper #(.GAP_CYC(STEP_WAIT_CYC)) u_stepper (
    .pclk      (pclk),
    .presetn   (presetn),
    .clk_en    (clk_en),
    .go        (st_go),
    .outward   (st_out),
    .busy      (st_busy),
    .dir_level (st_dir),
    .pulse_n   (st_pulse_n),
    .done      (st_done)
  );

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign cable   = cable_q;

  // at most one select line low outside binary mode; the cable lags the mode by one register
  property p_one_line;
    @(posedge pclk) disable iff (!presetn)
    ($past(clk_en) && $past(ctrl_q[CTRL_MODE_LSB +: 2]) != 2'b01) |-> ($countones(~cable_q.unit_choice_n) <= 1);
  endproperty
  a_one_line: assert property (p_one_line) else $error("several select lines low");
  // no step pulse before the power-up wait ends
  property p_no_early_step;
    @(posedge pclk) disable iff (!presetn)
    !cable_q.head_advance_pulse_n |-> dc_ok;
  endproperty
  a_no_early_step: assert property (p_no_early_step) else $error("step before power settle");
  // step pulse only with record enable inactive and drive selected
  property p_step_clean;
    @(posedge pclk) disable iff (!presetn)
    !cable_q.head_advance_pulse_n |-> (cable_q.record_enable_n && cable_q.unit_choice_n != 4'hF);
  endproperty
  a_step_clean: assert property (p_step_clean) else $error("step without select or with write");
  // homing steps outward; a frozen clock enable would hold the stepper idle
  property p_home_out;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && cs_q == FDSEL_C_HOME && st_go) |=> (st_busy && st_dir);
  endproperty
  a_home_out: assert property (p_home_out) else $error("homing step not outward");
  // track count cleared once homing completes
  property p_home_zero;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && cs_q == FDSEL_C_HOME && !st_busy && at_zero) |=> (track_q == 8'h00 && done_q);
  endproperty
  a_home_zero: assert property (p_home_zero) else $error("track count not cleared at zero");
  // standard mode side level follows the side field
  property p_side_std;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && ctrl_q[CTRL_MODE_LSB +: 2] == 2'b00) |=> (cable_q.side_choice_n == !$past(side));
  endproperty
  a_side_std: assert property (p_side_std) else $error("side choice level wrong");
  // apb answers one cycle after the access phase starts
  property p_apb_ans;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && psel && penable && !pready_q) |=> pready_q;
  endproperty
  a_apb_ans: assert property (p_apb_ans) else $error("apb answer late");

endmodule // fdsel_ctrl

// ### sim/fdsel_drive_model.sv
// behavioural drive at one cable position: head position and track zero sensor
`timescale 1ns/1ps
module fdsel_drive_model
  import fdsel_pkg::*;
#(
  parameter int unsigned POS         = 0,
  parameter int unsigned START_TRACK = 1
)
(
  input  wire fdsel_cable_t cable,
  output logic              track_zero_flag_n,
  output logic [7:0]        track,
  output logic [7:0]        steps
);
  logic sel;

  // selected only by a low level on the line of its switch position
  assign sel = (cable.unit_choice_n[POS] === 1'b0);
  // head position is random after power up, so start away from track zero
  initial
  begin
    track = START_TRACK[7:0];
    steps = 8'h00;
  end
  // head moves on the trailing edge, one track, never while writing or unselected
  always @(posedge cable.head_advance_pulse_n)
  begin
    if (sel && cable.record_enable_n === 1'b1)
    begin
      steps = steps + 8'h01;
      if (cable.seek_heading_level)
        track = (track == 8'h00) ? 8'h00 : track - 8'h01;
      else
        track = track + 8'h01;
    end
  end
  // flag driven only while selected; the cable pull-up holds it high otherwise
  assign track_zero_flag_n = sel ? (track != 8'h00) : 1'b1;
endmodule // fdsel_drive_model

// ### sim/tb.sv
// self-checking bench: register access, select decoding, power wait and homing
`timescale 1ns/1ps
module tb;
  import fdsel_pkg::*;
  localparam int unsigned DCW = 50;
  localparam int unsigned SPW = 100;
  localparam int unsigned GAPW = 100;
  logic         pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, tz_n, er;
  logic [7:0]   paddr, trk, stp;
  logic [31:0]  pwdata, prdata, rd;
  fdsel_cable_t cable;
  int           errors, comparisons;

  fdsel_ctrl #(.DC_WAIT_CYC(DCW), .SPIN_WAIT_CYC(SPW), .STEP_WAIT_CYC(GAPW)) DUT (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .track_zero_flag_n(tz_n), .cable(cable));

  fdsel_drive_model #(.POS(0), .START_TRACK(1)) drive (
    .cable(cable), .track_zero_flag_n(tz_n), .track(trk), .steps(stp));

  // free running 25 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic summarize();
    if (errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check(n < 50, 1'b1, "apb answer");
  endtask

  task automatic t_reset();
    check(cable, CABLE_IDLE, "cable idle in reset");
    check(pready, 1'b0, "pready in reset");
  endtask

  // commands in the power wait are dropped; status comes up after the waits
  task automatic t_power();
    apb(1'b1, ADDR_CMD, 32'h0000_0001);
    apb(1'b0, ADDR_STAT, 32'h0);
    check(rd[1], 1'b0, "busy during power wait");
    check(stp, 8'h00, "no step during power wait");
    repeat (DCW + SPW + 20) @(posedge pclk);
    apb(1'b0, ADDR_STAT, 32'h0);
    check(rd & 32'h0000_0019, 32'h0000_0019, "powered dc and spin ok");
  endtask

  task automatic t_regs();
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rd, CTRL_RESET, "ctrl reset value, position 1");
    apb(1'b0, 8'h10, 32'h0);
    check(er, 1'b1, "unmapped read error");
    apb(1'b1, ADDR_CTRL, 32'h0000_1013);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rd & 32'h0000_333F, 32'h0000_1013, "ctrl read back");
  endtask

  // every addressing mode: {lines, side_n, power_reduce_n} per ctrl value
  task automatic t_select();
    logic [31:0] cv [6] = '{32'h0000_1000, 32'h0000_100B, 32'h0000_1015, 32'h0000_1122,
                            32'h0000_112A, 32'h0000_3000};
    logic [5:0]  ex [6] = '{6'b1110_1_1, 6'b0111_0_1, 6'b0100_1_1, 6'b1011_1_1,
                            6'b1101_1_1, 6'b1110_1_0};
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b1, ADDR_CTRL, cv[i]);
      for (int k = 0; k < 8 && cable.unit_choice_n !== ex[i][5:2]; k++)
        @(posedge pclk);
      check({cable.unit_choice_n, cable.side_choice_n, cable.power_reduce_n}, ex[i],
            "select lines");
      check(cable.record_enable_n, 1'b1, "record enable idle");
    end
  endtask

  // poll status until the sequencer drops busy
  task automatic wait_idle();
    int n;
    for (n = 0; n < 2000; n++)
    begin
      apb(1'b0, ADDR_STAT, 32'h0);
      if (rd[1] === 1'b0)
        break;
    end
    check(n < 2000, 1'b1, "command finished");
  endtask

  // homing from track 1 must give exactly one outward step
  task automatic t_home();
    apb(1'b1, ADDR_CTRL, 32'h0000_0000);
    apb(1'b1, ADDR_CMD, 32'h0000_0001);
    wait_idle();
    check(stp, 8'h01, "one step per track");
    check(trk, 8'h00, "head at track zero");
    apb(1'b0, ADDR_TRACK, 32'h0);
    check(rd[7:0], 8'h00, "track count cleared");
    check(cable.unit_choice_n, 4'hF, "released after home");
    check(tz_n, 1'b1, "flag idle when unselected");
    // the flag only means something while selected, so hold the selection before reading it
    apb(1'b1, ADDR_CTRL, 32'h0000_1000);
    repeat (4) @(posedge pclk);
    apb(1'b0, ADDR_STAT, 32'h0);
    check(rd[5:2] & 4'h9, 4'h1, "at track0, no error");
  endtask

  // seek inward three tracks, then one outward step
  task automatic t_seek();
    apb(1'b1, ADDR_CMD, 32'h0000_0302);
    wait_idle();
    check(trk, 8'h03, "seek inward to track 3");
    check(stp, 8'h04, "three more steps");
    apb(1'b0, ADDR_TRACK, 32'h0);
    check(rd[15:0], 16'h0303, "target and count after seek");
    apb(1'b0, ADDR_STAT, 32'h0);
    check(rd[6:5], 2'b10, "seek done without error");
    apb(1'b1, ADDR_CMD, 32'h0000_0007);
    wait_idle();
    check(trk, 8'h02, "one outward step");
    apb(1'b0, ADDR_TRACK, 32'h0);
    check(rd[15:0], 16'h0202, "count after outward step");
  endtask

  // cut a hang short
  initial
  begin
    repeat (20000) @(posedge pclk);
    errors++;
    summarize();
  end

  // reset, then the scenarios in order
  initial
  begin
    errors = 0;
    comparisons = 0;
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (6) @(posedge pclk);
    t_reset();
    presetn <= 1'b1;
    t_power();
    t_regs();
    t_select();
    t_home();
    t_seek();
    summarize();
  end
endmodule // tb
